// *** logic/cpio_pkg.sv ***
// package: constants and carrier types of the card punch i/o handshake
package cpio_pkg;

  // ==================================================================
  // widths and host word layout (bit n of the host word at index 16-n)
  localparam int HW_W      = 16;
  localparam int CHAR_W    = 12;
  localparam int HW_BIT01  = 15;
  localparam int HW_BIT04  = 12;
  localparam int HW_BIT14  = 2;
  localparam int HW_BIT15  = 1;
  localparam int HW_BIT16  = 0;
  localparam int STAT_BUSY = 15;
  localparam int STAT_STATUS_INTERRUPT = 14;
  localparam int STAT_DATA_INTERRUPT = 13;

  // ==================================================================
  // host port addresses
  localparam logic [0:0] ADDR_DATA = 1'h0;
  localparam logic [0:0] ADDR_CTRL = 1'h1;

  // ==================================================================
  // timing: one delay stage per 1 us tick at a 40 ns clock
  localparam int CLK_NS    = 40;
  localparam int TICK_NS   = 1000;
  localparam int SETUP_NS  = 1000;
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRESC_W   = 5;
  typedef logic [PRESC_W-1:0] cpio_presc_t;
  localparam cpio_presc_t TICK_LAST = cpio_presc_t'(TICK_CYC - 1);
  localparam cpio_presc_t PRESC_ONE = 5'h01;
  localparam logic [7:0]  CNT_ONE   = 8'h01;
  localparam logic [7:0]  CNT_MAX   = 8'hff;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [0:0]        addr;
    logic [HW_W-1:0]   wdata;
  } cpio_hreq_t;

  typedef struct packed {
    logic              cip_n;
    logic              req_n;
    logic              prt_n;
    logic              rcv_n;
    logic              rbf_n;
    logic              operator_request_n_n;
    logic              pon_n;
    logic [CHAR_W-1:0] rdata;
  } cpio_pin_in_t;

  localparam int PIN_IN_W = $bits(cpio_pin_in_t);
  localparam logic [PIN_IN_W-1:0] PIN_IN_IDLE = '1;

  typedef struct packed {
    logic [CHAR_W-1:0] data;
    logic              start_cycle_strobe_n;
    logic              transfer_pulse_n;
    logic              clear_read_buffer_n;
    logic              operator_alert_n;
  } cpio_pin_out_t;

  typedef struct packed {
    cpio_pin_out_t     pout;
    logic [HW_W-1:0]   host_rdata;
    logic              data_interrupt;
    logic              status_interrupt;
    logic              cycle_complete_n;
    cpio_presc_t       presc;
    logic              delay_stage_first;
    logic              delay_stage_second;
    logic              delay_stage_third;
    logic              strobe;
    logic              buf_ctrl;
    logic              load_input;
    logic              unload_input;
    logic              operator_alert_latch;
    logic              cycle_start_latch;
    logic              xfr_first;
    logic              xfr_second;
    logic              transfer_pulse;
    logic              cip_d;
    logic              operator_request_n_d;
  } cpio_state_t;

  localparam cpio_state_t STATE_RST = '{
    pout: '{data: '0, start_cycle_strobe_n: 1'b1, transfer_pulse_n: 1'b1,
            clear_read_buffer_n: 1'b1, operator_alert_n: 1'b1},
    cycle_start_latch: 1'b1,
    default: '0
  };

endpackage : cpio_pkg

// *** logic/cpio_sync.sv ***
// module: three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module cpio_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    IDLE = '0
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  din,
  output logic [W-1:0]       dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] mid;
    logic [W-1:0] last;
    logic [W-1:0] q;
  } cpio_sync_t;

  cpio_sync_t s;
  cpio_sync_t next_s;

  // ==================================================================
  // shift chain; a bit counts once stages two and three agree
  always_comb
  begin
    next_s      = s;
    next_s.meta = din;
    next_s.mid  = s.meta;
    next_s.last = s.mid;
    for (int i = 0; i < W; i++)
    begin
      if (s.mid[i] == s.last[i])
      begin
        next_s.q[i] = s.last[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{meta: IDLE, mid: IDLE, last: IDLE, q: IDLE};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.q;

endmodule : cpio_sync

`default_nettype wire

// *** logic/cpio_ctrl.sv ***
// module: card punch i/o handshake control, top level
//
// Contract
// - Set motion lines, then drive start strobe low; peripheral latches, enters state 1.
// - Char request in load phase raises the data interrupt; code does so only if load was asked in control word.
// - Host character write: buffer, drive lines, clear interrupt, send transfer pulse.
// - Unload phase raises data interrupt only if unload was asked in control word.
// - Host read in unload: clear interrupt, return character, send transfer pulse.
// - Control word bit 04 during unload drives clear-read-buffer low.
// - Operator request raises the status interrupt.
// - Control word bit 1 drives operator alert low.
// - Every host write loads word bits 05..16 into output buffer at once.
// - Data held until next write; control bits until cycle starts; reset clears.
// - Motion data stable at least 1 us before start strobe falls.
// - Start write (bit 16, not 04) runs three-stage delay to the strobe.
// - Cycle-in-progress clears first stage; strobe drops three stages later.
// - Output buffer cleared on the edge that drops the start strobe; code does so only if it holds control bits and no write comes.
// - Power-on hold suppresses the start strobe.
// - Busy status from control word until peripheral finishes.
// - Transfer pulse rises two clocks after the data interrupt clears.
// - Transfer pulse held until request or read-valid is released.
`timescale 1ns/1ps
`default_nettype none

module cpio_ctrl (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire cpio_pkg::cpio_hreq_t   hreq,
  output logic [cpio_pkg::HW_W-1:0]   host_rdata,
  output logic                        data_interrupt,
  output logic                        status_interrupt,
  output logic                        cycle_complete_n,
  input  wire cpio_pkg::cpio_pin_in_t pin_in,
  output cpio_pkg::cpio_pin_out_t     pin_out
);

  // ==================================================================
  // reset release
  logic [1:0]                        rst_pipe;
  logic                              rst_n;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_pipe <= 2'h0;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ==================================================================
  // pin synchronisers
  logic [cpio_pkg::PIN_IN_W-1:0]     pin_q;
  cpio_pkg::cpio_pin_in_t            pin;

  cpio_sync #(
    .W    (cpio_pkg::PIN_IN_W),
    .IDLE (cpio_pkg::PIN_IN_IDLE)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (pin_in),
    .dout    (pin_q)
  );

  assign pin = cpio_pkg::cpio_pin_in_t'(pin_q);

  // ==================================================================
  // host port decode
  function automatic logic hit(input cpio_pkg::cpio_hreq_t r, input logic is_wr, input logic [0:0] a);
    hit = (is_wr ? r.wr : r.rd) && (r.addr == a);
  endfunction : hit

  cpio_pkg::cpio_state_t             s;
  cpio_pkg::cpio_state_t             next_s;
  logic                              cip;
  logic                              unload;
  logic                              req;
  logic                              prt;
  logic                              rcv;
  logic                              operator_request_n;
  logic                              pon;
  logic                              tick;
  logic                              ctrl_wr;
  logic                              data_wr;
  logic                              data_rd;
  logic                              stat_rd;
  logic                              start_wr;
  logic                              want_data_interrupt;
  logic                              xfr_busy;
  logic                              take;
  logic                              released;
  logic [cpio_pkg::HW_W-1:0]         stat_word;

  always_comb
  begin
    cip       = !pin.cip_n;
    unload    = !pin.rbf_n;
    req       = !pin.req_n;
    prt       = !pin.prt_n;
    rcv       = !pin.rcv_n;
    operator_request_n     = !pin.operator_request_n_n;
    pon       = pin.pon_n;
    ctrl_wr   = hit(hreq, 1'b1, cpio_pkg::ADDR_CTRL);
    data_wr   = hit(hreq, 1'b1, cpio_pkg::ADDR_DATA);
    data_rd   = hit(hreq, 1'b0, cpio_pkg::ADDR_DATA);
    stat_rd   = hit(hreq, 1'b0, cpio_pkg::ADDR_CTRL);
    start_wr  = ctrl_wr && hreq.wdata[cpio_pkg::HW_BIT16] && !hreq.wdata[cpio_pkg::HW_BIT04];
    tick      = (s.presc == cpio_pkg::TICK_LAST);
    xfr_busy  = s.xfr_first || s.xfr_second || s.transfer_pulse;
    want_data_interrupt = (req && !prt && s.load_input) || (req && prt) || (rcv && unload && s.unload_input);
    take      = s.data_interrupt && (unload ? data_rd : data_wr);
    released  = unload ? pin.rcv_n : pin.req_n;
    stat_word = '0;
    stat_word[cpio_pkg::STAT_BUSY] = s.cycle_complete_n;
    stat_word[cpio_pkg::STAT_STATUS_INTERRUPT] = s.status_interrupt;
    stat_word[cpio_pkg::STAT_DATA_INTERRUPT] = s.data_interrupt;
  end

  // ==================================================================
  // next state
  always_comb
  begin
    next_s            = s;
    next_s.presc      = tick ? '0 : s.presc + cpio_pkg::PRESC_ONE;
    next_s.host_rdata = '0;
    next_s.cip_d      = cip;
    next_s.operator_request_n_d    = operator_request_n;

    // host reads answer in the following cycle only
    if (data_rd)
    begin
      next_s.host_rdata[cpio_pkg::CHAR_W-1:0] = pin.rdata;
    end
    else if (stat_rd)
    begin
      next_s.host_rdata = stat_word;
    end

    // output buffer, control word fields
    if (!cip)
    begin
      next_s.pout.clear_read_buffer_n = 1'b1;
    end
    if (s.cip_d && !cip)
    begin
      next_s.operator_alert_latch = 1'b0;
    end
    if (hreq.wr)
    begin
      next_s.pout.data = hreq.wdata[cpio_pkg::CHAR_W-1:0];
      next_s.buf_ctrl  = ctrl_wr;
    end
    if (ctrl_wr)
    begin
      if (hreq.wdata[cpio_pkg::HW_BIT04])
      begin
        if (unload)
        begin
          next_s.pout.clear_read_buffer_n = 1'b0;
        end
      end
      else
      begin
        next_s.load_input           = hreq.wdata[cpio_pkg::HW_BIT14];
        next_s.unload_input         = hreq.wdata[cpio_pkg::HW_BIT15];
        next_s.operator_alert_latch = hreq.wdata[cpio_pkg::HW_BIT01];
      end
    end

    // start strobe delay chain
    if (start_wr)
    begin
      next_s.delay_stage_first = 1'b1;
      next_s.presc             = '0;
    end
    else if (cip)
    begin
      next_s.delay_stage_first = 1'b0;
    end
    if (tick)
    begin
      next_s.delay_stage_second = s.delay_stage_first;
      next_s.delay_stage_third  = s.delay_stage_second;
      next_s.strobe             = s.delay_stage_third;
    end
    if (!pon)
    begin
      next_s.strobe = 1'b0;
    end
    if (s.strobe && !next_s.strobe && s.buf_ctrl && !hreq.wr)
    begin
      next_s.pout.data = '0;
      next_s.buf_ctrl  = 1'b0;
    end

    // cycle start latch and busy status
    if (start_wr)
    begin
      next_s.cycle_start_latch = 1'b0;
    end
    else if (cip && (s.strobe || s.operator_alert_latch))
    begin
      next_s.cycle_start_latch = 1'b1;
    end
    next_s.cycle_complete_n = !next_s.cycle_start_latch || cip;

    // status interrupt: set wins over the status read
    if (stat_rd)
    begin
      next_s.status_interrupt = 1'b0;
    end
    if ((operator_request_n && !s.operator_request_n_d) || (s.cycle_complete_n && !next_s.cycle_complete_n))
    begin
      next_s.status_interrupt = 1'b1;
    end

    // transfer pulse chain
    next_s.xfr_second = s.xfr_first;
    if (s.xfr_second)
    begin
      next_s.transfer_pulse = 1'b1;
    end
    if (s.transfer_pulse)
    begin
      next_s.xfr_first  = 1'b0;
      next_s.xfr_second = 1'b0;
      if (released)
      begin
        next_s.transfer_pulse = 1'b0;
      end
    end

    // data interrupt level
    if (take)
    begin
      next_s.data_interrupt = 1'b0;
      next_s.xfr_first      = 1'b1;
    end
    else if (want_data_interrupt && !xfr_busy && !s.data_interrupt)
    begin
      next_s.data_interrupt = 1'b1;
    end

    next_s.pout.start_cycle_strobe_n = !next_s.strobe;
    next_s.pout.transfer_pulse_n     = !next_s.transfer_pulse;
    next_s.pout.operator_alert_n     = !next_s.operator_alert_latch;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= cpio_pkg::STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign host_rdata       = s.host_rdata;
  assign data_interrupt   = s.data_interrupt;
  assign status_interrupt = s.status_interrupt;
  assign cycle_complete_n = s.cycle_complete_n;
  assign pin_out          = s.pout;

  // ==================================================================
  // checks
  logic [7:0] stable_cnt;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable_cnt <= '0;
    end
    else if (next_s.pout.data != s.pout.data)
    begin
      stable_cnt <= '0;
    end
    else if (stable_cnt != cpio_pkg::CNT_MAX)
    begin
      stable_cnt <= stable_cnt + cpio_pkg::CNT_ONE;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_data_interrupt_drop;
    take ##1 !s.data_interrupt;
  endsequence

  sequence seq_pulse_lag;
    !s.transfer_pulse ##1 s.transfer_pulse;
  endsequence

  data_interrupt_on_req_a: assert property (want_data_interrupt && !xfr_busy && !s.data_interrupt |=> s.data_interrupt)
    else $error("data interrupt not raised on request");
  data_interrupt_level_a: assert property (s.data_interrupt && !take |=> s.data_interrupt)
    else $error("data interrupt dropped without transfer");
  xfer_lag_a: assert property (seq_data_interrupt_drop |=> seq_pulse_lag)
    else $error("transfer pulse not two clocks after interrupt clear");
  pulse_hold_a: assert property (s.transfer_pulse && !released |=> s.transfer_pulse)
    else $error("transfer pulse ended before release");
  read_char_a: assert property (data_rd && take |=> s.host_rdata[cpio_pkg::CHAR_W-1:0] == $past(pin.rdata)
                                && !s.data_interrupt)
    else $error("unload read did not return character");
  buf_load_a: assert property (hreq.wr |=> s.pout.data == $past(hreq.wdata[cpio_pkg::CHAR_W-1:0]))
    else $error("output buffer not loaded");
  setup_time_a: assert property ($rose(s.strobe) |-> stable_cnt >= 8'(cpio_pkg::SETUP_CYC))
    else $error("motion data not stable before start strobe");
  start_delay_a: assert property ($rose(s.strobe) |-> $past(s.delay_stage_first, 3 * cpio_pkg::TICK_CYC)
                                  && s.pout.data == $past(s.pout.data, 3 * cpio_pkg::TICK_CYC))
    else $error("start strobe without three-stage delay");
  stage_clear_a: assert property (cip && !start_wr |=> !s.delay_stage_first)
    else $error("first stage not cleared by cycle in progress");
  buf_clear_a: assert property ($fell(s.strobe) && $past(s.buf_ctrl) && !$past(hreq.wr) |-> s.pout.data == '0)
    else $error("buffer not cleared with strobe drop");
  pon_block_a: assert property (!pon |=> s.pout.start_cycle_strobe_n)
    else $error("start strobe during power-on hold");
  cycle_latch_a: assert property (start_wr |=> !s.cycle_start_latch && s.cycle_complete_n)
    else $error("start write did not mark busy");
  busy_hold_a: assert property (cip |=> s.cycle_complete_n)
    else $error("busy dropped during cycle");
  op_status_interrupt_a: assert property (operator_request_n && !s.operator_request_n_d |=> s.status_interrupt)
    else $error("operator request without status interrupt");
  op_alert_a: assert property (ctrl_wr && hreq.wdata[cpio_pkg::HW_BIT01] && !hreq.wdata[cpio_pkg::HW_BIT04]
                               |=> !s.pout.operator_alert_n)
    else $error("operator alert not driven");
  clr_read_a: assert property (ctrl_wr && hreq.wdata[cpio_pkg::HW_BIT04] && unload
                               |=> !s.pout.clear_read_buffer_n)
    else $error("clear read buffer not driven");

endmodule : cpio_ctrl

`default_nettype wire

// *** test/cpio_card_model.sv ***
// model: card reader-punch peripheral on the far side of the i/o control
`timescale 1ns/1ps
`default_nettype none

module cpio_card_model #(
  parameter int N_CHARS = 96,
  parameter int CIP_DLY = 300
) (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    key1,
  input  wire logic                    pon_n,
  input  wire cpio_pkg::cpio_pin_out_t pin_out,
  output cpio_pkg::cpio_pin_in_t       pin_in
);
  // ==================================================================
  // control counter and character handshake
  cpio_pkg::cpio_pin_in_t p;
  logic [2:0]             st;
  logic                   al_d;
  logic                   xp;
  logic                   sep;
  int                     n;
  int                     wt;

  function automatic logic [11:0] chr(input int i);
    return 12'h0a0 + 12'(i);
  endfunction : chr

  assign xp = ~pin_out.transfer_pulse_n;

  always_comb
  begin
    pin_in         = p;
    pin_in.operator_request_n_n = ~key1;
    pin_in.pon_n   = pon_n;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p    <= '1;
      st   <= 3'h0;
      al_d <= 1'b1;
      sep  <= 1'b0;
      n    <= 0;
      wt   <= 0;
    end
    else
    begin
      al_d <= pin_out.operator_alert_n;
      case (st)
        3'h0:
        begin
          p  <= '1;
          n  <= 0;
          wt <= 0;
          if (!pin_out.start_cycle_strobe_n)
          begin
            st  <= 3'h1;
            sep <= pin_out.data[8]; // separate print is word bit 08
          end
          else if (al_d && !pin_out.operator_alert_n)
          begin
            st      <= 3'h4;
            p.cip_n <= 1'b0;
          end
        end
        3'h1:
        begin
          if (p.cip_n)
          begin
            wt <= wt + 1;
            if (wt == CIP_DLY)
              p.cip_n <= 1'b0;
          end
          else if (xp && !p.req_n)
          begin
            p.req_n <= 1'b1;
            n       <= n + 1;
          end
          else if (!xp && p.req_n)
          begin
            if (n == N_CHARS)
              st <= 3'h2;
            else
              p.req_n <= 1'b0;
          end
        end
        3'h2:
        begin
          st <= 3'h3;
          wt <= 0;
          n  <= 0;
        end
        // print load phase only when separate print was asked
        3'h3:
        begin
          if (!sep)
            st <= 3'h4;
          else if (xp && !p.req_n)
          begin
            p.req_n <= 1'b1;
            n       <= n + 1;
          end
          else if (!xp && p.req_n)
          begin
            if (n == N_CHARS)
            begin
              st      <= 3'h4;
              p.prt_n <= 1'b1;
            end
            else
            begin
              p.req_n <= 1'b0;
              p.prt_n <= 1'b0;
            end
          end
        end
        3'h4:
        begin
          wt <= wt + 1;
          n  <= 0;
          if (wt == 40)
            st <= 3'h5;
        end
        3'h5:
        begin
          p.rbf_n <= 1'b0;
          if (!pin_out.clear_read_buffer_n)
            st <= 3'h0;
          else if (xp && !p.rcv_n)
          begin
            p.rcv_n <= 1'b1;
            p.rdata <= ~p.rdata;
            n       <= n + 1;
          end
          else if (!xp && p.rcv_n)
          begin
            if (n == N_CHARS)
              st <= 3'h0;
            else if (p.rdata == chr(n))
              p.rcv_n <= 1'b0;
            else
              p.rdata <= chr(n);
          end
        end
        default:
          st <= 3'h0;
      endcase
    end
  end
endmodule : cpio_card_model

`default_nettype wire

// *** test/tb_card_punch_io_handshake.sv ***
// testbench: card punch i/o handshake against the peripheral model
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, lim) begin for (wc = 0; wc < lim && !(c); wc++) tick(1); \
  if (!(c)) begin err_total++; $display("[ERR] wait ran out"); close_out(); end end

module tb_card_punch_io_handshake;
  logic                      sys_clk;
  logic                      nrst;
  logic                      key1;
  logic                      pon_n;
  cpio_pkg::cpio_hreq_t      hreq;
  logic [cpio_pkg::HW_W-1:0] host_rdata;
  logic                      data_interrupt;
  logic                      status_interrupt;
  logic                      cycle_complete_n;
  cpio_pkg::cpio_pin_in_t    pin_in;
  cpio_pkg::cpio_pin_out_t   pin_out;
  int                        err_total;
  int                        n_checks;
  int                        wc;
  int                        k;

  cpio_ctrl i_cpio_ctrl (.sys_clk(sys_clk), .nrst(nrst), .hreq(hreq), .host_rdata(host_rdata),
    .data_interrupt(data_interrupt), .status_interrupt(status_interrupt),
    .cycle_complete_n(cycle_complete_n), .pin_in(pin_in), .pin_out(pin_out));
  cpio_card_model i_cpio_card_model (.sys_clk(sys_clk), .nrst(nrst), .key1(key1), .pon_n(pon_n),
    .pin_out(pin_out), .pin_in(pin_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==================================================================
  // bus cycles and helpers
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic tick(input int c);
    repeat (c)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask : tick

  task automatic hw(input logic [0:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    hreq.wr    <= 1'b1;
    hreq.addr  <= a;
    hreq.wdata <= w;
    @(posedge sys_clk);
    hreq <= '0;
    #1;
  endtask : hw

  task automatic hr(input logic [0:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    hreq.rd   <= 1'b1;
    hreq.addr <= a;
    @(posedge sys_clk);
    hreq <= '0;
    #1;
    d = host_rdata;
  endtask : hr

  // ==================================================================
  // scenarios
  task automatic t_reset();
    `CHK("buf_rst", 12'h000, pin_out.data)
    `CHK("strobe_rst", 1'b1, pin_out.start_cycle_strobe_n)
    `CHK("ccc_rst", 1'b0, cycle_complete_n)
  endtask : t_reset

  task automatic t_card();
    logic [15:0] d;
    int          i;
    hw(cpio_pkg::ADDR_CTRL, 16'h0bb7);
    `CHK("buf_ctrl", 12'hbb7, pin_out.data)
    `CHK("busy", 1'b1, cycle_complete_n)
    for (k = 0; k < 200 && pin_out.start_cycle_strobe_n !== 1'b0; k++) tick(1);
    `CHK("strobe_dly", 3 * cpio_pkg::TICK_CYC, k)
    `CHK("motion_hold", 12'hbb7, pin_out.data)
    `WAITC(pin_in.cip_n === 1'b0, 2000)
    for (k = 0; k < 200 && pin_out.start_cycle_strobe_n !== 1'b1; k++) tick(1);
    `CHK("strobe_rel", 1'b1, k >= 50 && k <= 80)
    `CHK("buf_clr", 12'h000, pin_out.data)
    // load phase, then print phase
    for (i = 0; i < 2 * 96; i++)
    begin
      `WAITC(data_interrupt === 1'b1, 500)
      hw(cpio_pkg::ADDR_DATA, 16'h0300 + 16'(i));
      `CHK("data_interrupt_clr", 1'b0, data_interrupt)
      for (k = 0; k < 20 && pin_out.transfer_pulse_n !== 1'b0; k++) tick(1);
      `CHK("xfr_dly", 2, k)
      `CHK("chr_out", 12'h300 + 12'(i), pin_out.data)
      `WAITC(pin_out.transfer_pulse_n === 1'b1, 50)
      `CHK("xfr_hold", 1'b1, pin_in.req_n)
    end
    for (i = 0; i < 8; i++)
    begin
      `WAITC(data_interrupt === 1'b1, 500)
      hr(cpio_pkg::ADDR_DATA, d);
      `CHK("rd_chr", 12'h0a0 + 12'(i), d[11:0])
      `CHK("data_interrupt_rd", 1'b0, data_interrupt)
    end
    `WAITC(data_interrupt === 1'b1, 500)
    // take the pending character, then stop before the next request
    hr(cpio_pkg::ADDR_DATA, d);
    `CHK("rd_last", 12'h0a8, d[11:0])
    hw(cpio_pkg::ADDR_CTRL, 16'h1000);
    `CHK("clr_rd", 1'b0, pin_out.clear_read_buffer_n)
    `WAITC(cycle_complete_n === 1'b0, 200)
    `CHK("cip_rel", 1'b1, pin_in.cip_n)
    `WAITC(status_interrupt === 1'b1, 50)
    hr(cpio_pkg::ADDR_CTRL, d);
    `CHK("stat_done", 2'b01, d[15:14])
    hr(cpio_pkg::ADDR_CTRL, d);
    `CHK("status_interrupt_clr", 1'b0, d[14])
    `CHK("clr_rd_rel", 1'b1, pin_out.clear_read_buffer_n)
  endtask : t_card

  task automatic t_operator();
    logic [15:0] d;
    @(posedge sys_clk);
    key1 <= 1'b1;
    `WAITC(status_interrupt === 1'b1, 50)
    @(posedge sys_clk);
    key1 <= 1'b0;
    hr(cpio_pkg::ADDR_CTRL, d);
    `CHK("stat_operator_request_n", 1'b1, d[14])
    hw(cpio_pkg::ADDR_CTRL, 16'h8000);
    `CHK("alert", 1'b0, pin_out.operator_alert_n)
    `WAITC(pin_in.rbf_n === 1'b0, 800)
    tick(20);
    `CHK("no_unload_data_interrupt", 1'b0, data_interrupt)
    hw(cpio_pkg::ADDR_CTRL, 16'h1000);
    `CHK("clr_rd_op", 1'b0, pin_out.clear_read_buffer_n)
    `WAITC(pin_in.cip_n === 1'b1, 100)
  endtask : t_operator

  task automatic t_power();
    logic bad;
    bad = 1'b0;
    @(posedge sys_clk);
    pon_n <= 1'b0;
    tick(6);
    hw(cpio_pkg::ADDR_CTRL, 16'h0001);
    for (k = 0; k < 120; k++)
    begin
      tick(1);
      if (pin_out.start_cycle_strobe_n !== 1'b1)
        bad = 1'b1;
    end
    `CHK("pon_hold", 1'b0, bad)
  endtask : t_power

  // ==================================================================
  // main sequence
  initial
  begin
    nrst      = 1'b0;
    key1      = 1'b0;
    pon_n     = 1'b1;
    hreq      = '0;
    err_total = 0;
    n_checks  = 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(4);
    t_reset();
    t_card();
    t_operator();
    t_power();
    close_out();
  end
endmodule : tb_card_punch_io_handshake

`default_nettype wire
